/* logic/wdc_consts.svh */
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH

// Register byte offsets on the bus
`define WDC_OFF_WD_CONTROL  12'h0d8
`define WDC_OFF_IRQ_ENABLE  12'h0e8
`define WDC_OFF_IRQ_PRIO    12'h0f8
`define WDC_OFF_TIMED_ACC   12'h0c4

// Watchdog control field positions
`define WDC_BIT_BAUD_DBL    7
`define WDC_BIT_PWR_ON      6
`define WDC_BIT_IRQ_FLAG    3
`define WDC_BIT_RST_CAUSE   2
`define WDC_BIT_RST_EN      1
`define WDC_BIT_RESTART     0

// Interrupt enable and priority field positions
`define WDC_BIT_WD_IRQ_EN   4
`define WDC_BIT_WD_IRQ_PRI  4
`define WDC_IRQ_LOW_MSB     4
`define WDC_IRQ_EN_RSV      3'h7
`define WDC_IRQ_PRI_RSV     3'h0

// Reset values
`define WDC_IRQ_LOW_RST     5'h00

// Timed access keys and window
`define WDC_TA_KEY_FIRST    8'haa
`define WDC_TA_KEY_SECOND   8'h55
`define WDC_TA_WINDOW       8'h10

// Timing counts in clk_sys cycles
`define WDC_RST_DELAY       512
`define WDC_WD_PERIOD_DEF   131072

`endif

/* logic/wdc_pkg.sv */
package wdc_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } wdc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } wdc_apb_rsp_t;

   typedef enum logic [1:0] {
      TA_IDLE,
      TA_ARMED,
      TA_OPEN
   } wdc_ta_state_t;

endpackage

/* logic/wdc_top.sv */
// Functional notes
// - Power-up sets the power-on flag.
// - Power-on flag stays set until software writes it clear.
// - Watchdog time-out sets the watchdog interrupt flag.
// - Interrupt flag stays set until software or a reset clears it.
// - Watchdog-caused reset sets the reset cause flag; software clears it.
// - Power-fail reset clears the reset cause flag.
// - With reset enable at 0 the watchdog never touches the cause flag.
// - Reset enable bit arms the watchdog's device reset.
// - Restart bit restarts the watchdog count and clears itself.
// - Time-out raises interrupt; with reset enabled, reset follows 512 clocks later.
// - External reset loads control with 0x000xx0, x bits kept.
// - Cause flag set by watchdog reset, cleared by power resets, kept by external.
// - Power-on, reset enable, irq flag, restart need timed access; others free.
// - Baud-doubling bit doubles second serial port rate in modes 1-3.
// - Interrupt enable bit 4 gates the watchdog interrupt request.
// - Top three interrupt enable bits read as 1.
// - Priority bit 4 selects watchdog interrupt priority; top three reserved.
`timescale 1ns/1ps
`default_nettype none
`include "wdc_consts.svh"

module wdc_top #(
   parameter int WD_PERIOD = `WDC_WD_PERIOD_DEF
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire wdc_pkg::wdc_apb_req_t apbReq,
   output wdc_pkg::wdc_apb_rsp_t      apbRsp,
   input  wire logic                  extRst,
   input  wire logic                  pwrFailRst,
   output logic                       wdResetOut,
   output logic                       wdIrqReq,
   output logic                       wdIrqPriority,
   output logic                       serial1BaudDoubler
);
   import wdc_pkg::*;

   localparam int CNT_W = $clog2(WD_PERIOD);
   localparam int DLY_W = $clog2(`WDC_RST_DELAY);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WD_PERIOD - 1);
   localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(`WDC_RST_DELAY - 1);

   if (WD_PERIOD < 2) begin : g_chk
      $error("WD_PERIOD must be at least 2");
   end

   if (`WDC_RST_DELAY < 2) begin : g_chk_dly
      $error("reset delay must be at least 2");
   end

   if (`WDC_TA_WINDOW == 8'h00) begin : g_chk_win
      $error("timed access window must not be empty");
   end

   function automatic logic addrHit(input logic [11:0] addr,
                                    input logic [11:0] off);
      addrHit = (addr == off);
   endfunction

   // Key byte written to the timed access register
   function automatic logic keyHit(input logic       take,
                                   input logic       hit,
                                   input logic [7:0] data,
                                   input logic [7:0] key);
      keyHit = take & hit & (data == key);
   endfunction

   // Bus decode
   logic            accessPh;
   logic            setupPh;
   logic            wrTake;
   logic            hitCtl;
   logic            hitIe;
   logic            hitIp;
   logic            hitTa;
   logic            mapped;
   logic            wrCtl;
   logic            wrCtlProt;
   logic            wrIe;
   logic            wrIp;
   logic            taOpen;
   logic [7:0]      wByte;

   // Control bits
   logic            baudDbl_r;
   logic            pwrOn_r;
   logic            irqFlag_r;
   logic            rstCause_r;
   logic            rstEn_r;
   logic            restart_r;
   logic [4:0]      irqEnLow_r;
   logic [4:0]      irqPriLow_r;

   // Timed access
   wdc_ta_state_t   taState_r;
   wdc_ta_state_t   taState_nxt;
   logic [7:0]      taCnt_r;

   // Watchdog engine
   logic [CNT_W-1:0] wdCnt_r;
   logic             timeout;
   logic             restartReq;
   logic             dlyActive_r;
   logic [DLY_W-1:0] dlyCnt_r;
   logic             wdFire;
   logic             sysRst;
   logic             evtRst;
   logic             wdResetOut_r;

   logic [31:0]     prdata_r;
   logic [7:0]      rdByte;
   logic [7:0]      ctlByte;
   logic [7:0]      ieByte;
   logic [7:0]      ipByte;

   assign setupPh   = apbReq.psel & ~apbReq.penable;
   assign accessPh  = apbReq.psel & apbReq.penable;
   assign wrTake    = accessPh & apbReq.pwrite;
   assign hitCtl    = addrHit(apbReq.paddr, `WDC_OFF_WD_CONTROL);
   assign hitIe     = addrHit(apbReq.paddr, `WDC_OFF_IRQ_ENABLE);
   assign hitIp     = addrHit(apbReq.paddr, `WDC_OFF_IRQ_PRIO);
   assign hitTa     = addrHit(apbReq.paddr, `WDC_OFF_TIMED_ACC);
   assign mapped    = hitCtl | hitIe | hitIp | hitTa;
   assign wByte     = apbReq.pwdata[7:0];
   assign wrCtl     = wrTake & hitCtl;
   assign wrIe      = wrTake & hitIe;
   assign wrIp      = wrTake & hitIp;
   assign taOpen    = (taState_r == TA_OPEN);
   // Protected bits only move inside the open window
   assign wrCtlProt = wrCtl & taOpen;

   // Zero-wait slave; unmapped addresses answer with an error
   assign apbRsp = '{
      prdata:  prdata_r,
      pready:  1'b1,
      pslverr: accessPh & ~mapped
   };

   // Reset events from outside the block
   assign evtRst = extRst | pwrFailRst;

   // Any reset that reaches the whole device besides power-on
   assign sysRst = evtRst | wdFire;

   // Timed access sequencer
   always_comb begin
      taState_nxt = taState_r;
      case (taState_r)
         TA_IDLE: begin
            if (keyHit(wrTake, hitTa, wByte, `WDC_TA_KEY_FIRST)) begin
               taState_nxt = TA_ARMED;
            end
         end
         TA_ARMED: begin
            if (wrTake) begin
               if (keyHit(wrTake, hitTa, wByte, `WDC_TA_KEY_SECOND)) begin
                  taState_nxt = TA_OPEN;
               end else begin
                  taState_nxt = TA_IDLE;
               end
            end
         end
         TA_OPEN: begin
            // One protected write per key pair; last window cycle closes it
            if (wrCtl || taCnt_r == 8'h01) begin
               taState_nxt = TA_IDLE;
            end
         end
         default: begin
            taState_nxt = TA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         taState_r <= TA_IDLE;
      end else if (sysRst) begin
         taState_r <= TA_IDLE;
      end else begin
         taState_r <= taState_nxt;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         taCnt_r <= 8'h00;
      end else if (taState_nxt == TA_OPEN && taState_r != TA_OPEN) begin
         taCnt_r <= `WDC_TA_WINDOW;
      end else if (taCnt_r != 8'h00) begin
         taCnt_r <= taCnt_r - 8'h01;
      end
   end

   // Restart request and its self-clearing bit
   assign restartReq = wrCtlProt & wByte[`WDC_BIT_RESTART];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         restart_r <= 1'b0;
      end else begin
         restart_r <= restartReq & ~sysRst;
      end
   end

   // Free-running time-out counter
   assign timeout = (wdCnt_r == CNT_LAST);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wdCnt_r <= '0;
      end else if (sysRst || restartReq || timeout) begin
         wdCnt_r <= '0;
      end else begin
         wdCnt_r <= wdCnt_r + CNT_W'(1);
      end
   end

   // Delayed reset after time-out; a restart in the gap cancels it
   // An outside reset in the firing cycle wins, so no pulse follows it
   assign wdFire = dlyActive_r & (dlyCnt_r == DLY_LAST) & rstEn_r & ~evtRst;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dlyActive_r <= 1'b0;
      end else if (sysRst || restartReq || !rstEn_r) begin
         dlyActive_r <= 1'b0;
      end else if (timeout) begin
         dlyActive_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dlyCnt_r <= '0;
      end else if (sysRst || restartReq || !rstEn_r || !dlyActive_r) begin
         dlyCnt_r <= '0;
      end else begin
         dlyCnt_r <= dlyCnt_r + DLY_W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wdResetOut_r <= 1'b0;
      end else begin
         wdResetOut_r <= wdFire;
      end
   end

   // Power-on flag: power-up sets it, otherwise only protected software writes change it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwrOn_r <= 1'b1;
      end else if (wrCtlProt) begin
         pwrOn_r <= wByte[`WDC_BIT_PWR_ON];
      end
   end

   // Interrupt flag; a time-out beats a clearing write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqFlag_r <= 1'b0;
      end else if (sysRst) begin
         irqFlag_r <= 1'b0;
      end else if (timeout) begin
         irqFlag_r <= 1'b1;
      end else if (wrCtlProt) begin
         irqFlag_r <= wByte[`WDC_BIT_IRQ_FLAG];
      end
   end

   // Reset cause; external reset leaves it alone
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rstCause_r <= 1'b0;
      end else if (wdFire) begin
         rstCause_r <= 1'b1;
      end else if (pwrFailRst) begin
         rstCause_r <= 1'b0;
      end else if (wrCtl) begin
         rstCause_r <= wByte[`WDC_BIT_RST_CAUSE];
      end
   end

   // Reset enable survives every reset but power-on
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rstEn_r <= 1'b0;
      end else if (wrCtlProt) begin
         rstEn_r <= wByte[`WDC_BIT_RST_EN];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         baudDbl_r <= 1'b0;
      end else if (sysRst) begin
         baudDbl_r <= 1'b0;
      end else if (wrCtl) begin
         baudDbl_r <= wByte[`WDC_BIT_BAUD_DBL];
      end
   end

   // Interrupt enable and priority, low five bits stored
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqEnLow_r <= `WDC_IRQ_LOW_RST;
      end else if (sysRst) begin
         irqEnLow_r <= `WDC_IRQ_LOW_RST;
      end else if (wrIe) begin
         irqEnLow_r <= wByte[`WDC_IRQ_LOW_MSB:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqPriLow_r <= `WDC_IRQ_LOW_RST;
      end else if (sysRst) begin
         irqPriLow_r <= `WDC_IRQ_LOW_RST;
      end else if (wrIp) begin
         irqPriLow_r <= wByte[`WDC_IRQ_LOW_MSB:0];
      end
   end

   // Read assembly
   always_comb begin
      ctlByte = 8'h00;
      ctlByte[`WDC_BIT_BAUD_DBL]  = baudDbl_r;
      ctlByte[`WDC_BIT_PWR_ON]    = pwrOn_r;
      ctlByte[`WDC_BIT_IRQ_FLAG]  = irqFlag_r;
      ctlByte[`WDC_BIT_RST_CAUSE] = rstCause_r;
      ctlByte[`WDC_BIT_RST_EN]    = rstEn_r;
      ctlByte[`WDC_BIT_RESTART]   = restart_r;
   end
   assign ieByte  = {`WDC_IRQ_EN_RSV, irqEnLow_r};
   assign ipByte  = {`WDC_IRQ_PRI_RSV, irqPriLow_r};

   always_comb begin
      rdByte = 8'h00;
      if (hitCtl) begin
         rdByte = ctlByte;
      end else if (hitIe) begin
         rdByte = ieByte;
      end else if (hitIp) begin
         rdByte = ipByte;
      end else if (hitTa) begin
         rdByte = {7'h00, taOpen};
      end
   end

   // Data captured in setup so the access phase sees a flop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (setupPh && !apbReq.pwrite) begin
         prdata_r <= {24'h00_0000, rdByte};
      end
   end

   assign wdResetOut         = wdResetOut_r;
   assign wdIrqReq           = irqFlag_r & irqEnLow_r[`WDC_BIT_WD_IRQ_EN];
   assign wdIrqPriority      = irqPriLow_r[`WDC_BIT_WD_IRQ_PRI];
   assign serial1BaudDoubler = baudDbl_r;

endmodule

`default_nettype wire

/* testbench/wdc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module wdc_top_monitor #(
   parameter int WD_PERIOD = 64
) (
   input wire logic                  clk_sys,
   input wire logic                  rst,
   input wire wdc_pkg::wdc_apb_req_t apbReq,
   input wire wdc_pkg::wdc_apb_rsp_t apbRsp,
   input wire logic                  extRst,
   input wire logic                  pwrFailRst,
   input wire logic                  wdResetOut,
   input wire logic                  wdIrqReq,
   input wire logic                  wdIrqPriority,
   input wire logic                  serial1BaudDoubler
);
   import wdc_pkg::*;
   // Writes racing a reset event lose, so they are left out
   wire logic wr = apbReq.psel && apbReq.penable && apbReq.pwrite && !extRst && !pwrFailRst;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_baud_write: assert property (
      wr && apbReq.paddr == 12'h0d8 |=> wdResetOut || serial1BaudDoubler == $past(apbReq.pwdata[7]))
      else $error("baud bit not written");
   a_prio_write: assert property (
      wr && apbReq.paddr == 12'h0f8 |=> wdResetOut || wdIrqPriority == $past(apbReq.pwdata[4]))
      else $error("priority bit not written");
   a_irq_gate: assert property (
      wr && apbReq.paddr == 12'h0e8 && !apbReq.pwdata[4] |=> !wdIrqReq)
      else $error("request without enable");
   a_pulse_single: assert property (wdResetOut |=> !wdResetOut)
      else $error("reset pulse too long");
   a_irq_held: assert property (
      $fell(wdIrqReq) |-> wdResetOut || $past(wr || extRst || pwrFailRst))
      else $error("request dropped by itself");
   a_ext_clears: assert property (
      extRst |=> !serial1BaudDoubler && !wdIrqReq && !wdIrqPriority)
      else $error("external reset pattern wrong");
   a_fire_clears: assert property (
      wdResetOut |-> !serial1BaudDoubler && !wdIrqReq && !wdIrqPriority)
      else $error("watchdog reset pattern wrong");
   a_reset_cancels: assert property ((extRst || pwrFailRst) |=> !wdResetOut)
      else $error("reset pulse after reset event");
endmodule
`default_nettype wire

/* testbench/test_watchdog_control_and_reset_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_control_and_reset_flags;
   import wdc_pkg::*;
   logic         clk_sys = 0;
   logic         rst = 1;
   logic         extRst = 0;
   logic         pwrFailRst = 0;
   wdc_apb_req_t apbReq = '0;
   wdc_apb_rsp_t apbRsp;
   logic         wdResetOut, wdIrqReq, wdIrqPriority, serial1BaudDoubler;
   int           badCount = 0, numChecks = 0, cyc = 0, n;
   logic [7:0]   rd;
   logic         err;
   // Error, address, write data, read-back
   logic [28:0]  rows [4] = '{
      {1'b0, 12'h0d8, 8'hff, 8'hc4},
      {1'b0, 12'h0e8, 8'h1f, 8'hff},
      {1'b0, 12'h0f8, 8'hff, 8'h1f},
      {1'b1, 12'h100, 8'hff, 8'h00}};
   always #5 clk_sys = ~clk_sys;
   wdc_top #(.WD_PERIOD(64)) uut (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq),
      .apbRsp(apbRsp), .extRst(extRst), .pwrFailRst(pwrFailRst), .wdResetOut(wdResetOut),
      .wdIrqReq(wdIrqReq), .wdIrqPriority(wdIrqPriority),
      .serial1BaudDoubler(serial1BaudDoubler));
   task automatic test_done;
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata[7:0];
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      xfer(a, 1'b0, 8'h00);
      chk(rd, exp);
   endtask
   // Key pair opens the window for one control write
   task automatic prot(input logic [7:0] d);
      xfer(12'h0c4, 1'b1, 8'haa);
      xfer(12'h0c4, 1'b1, 8'h55);
      xfer(12'h0d8, 1'b1, d);
   endtask
   // One reset input high for one edge: 0 power-on, 1 external, 2 power-fail
   task automatic pulse(input int sel);
      case (sel)
         0: rst <= 1'b1;
         1: extRst <= 1'b1;
         default: pwrFailRst <= 1'b1;
      endcase
      @(posedge clk_sys);
      rst <= 1'b0;
      extRst <= 1'b0;
      pwrFailRst <= 1'b0;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         badCount++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(12'h0d8, 8'h40);
      rdc(12'h0e8, 8'he0);
      foreach (rows[i]) begin
         xfer(rows[i][27:16], 1'b1, rows[i][15:8]);
         rdc(rows[i][27:16], rows[i][7:0]);
         chk({7'h00, err}, {7'h00, rows[i][28]});
      end
      chk({6'h00, serial1BaudDoubler, wdIrqPriority}, 8'h03);
      prot(8'h03);
      rdc(12'h0d8, 8'h02);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wdIrqReq !== 1'b1);
      chk(n[7:0], 8'h3e);
      n = 0;
      while (wdResetOut !== 1'b1) begin
         @(posedge clk_sys);
         n++;
      end
      chk(n[7:0], 8'h00);
      chk(n[15:8], 8'h02);
      rdc(12'h0d8, 8'h06);
      xfer(12'h0d8, 1'b1, 8'h84);
      pulse(1);
      rdc(12'h0d8, 8'h06);
      pulse(2);
      rdc(12'h0d8, 8'h02);
      pulse(0);
      rdc(12'h0d8, 8'h40);
      // Without reset enable the time-out only flags
      xfer(12'h0e8, 1'b1, 8'h10);
      do @(posedge clk_sys); while (wdIrqReq !== 1'b1);
      repeat (600) begin
         @(posedge clk_sys);
         chk({7'h0, wdResetOut}, 8'h00);
      end
      xfer(12'h0e8, 1'b1, 8'h00);
      @(posedge clk_sys);
      chk({7'h00, wdIrqReq}, 8'h00);
      rdc(12'h0d8, 8'h48);
      test_done();
   end
endmodule
bind wdc_top wdc_top_monitor #(.WD_PERIOD(WD_PERIOD)) mon (.clk_sys(clk_sys), .rst(rst),
   .apbReq(apbReq), .apbRsp(apbRsp), .extRst(extRst), .pwrFailRst(pwrFailRst),
   .wdResetOut(wdResetOut), .wdIrqReq(wdIrqReq), .wdIrqPriority(wdIrqPriority),
   .serial1BaudDoubler(serial1BaudDoubler));
`default_nettype wire
